// *** clock_startup_defines.vh ***
// Constants for the clock source and start-up control block.
`ifndef CLOCK_STARTUP_DEFINES_VH
`define CLOCK_STARTUP_DEFINES_VH

// Register byte offsets on the APB.
`define OFS_TRIM 8'h00
`define OFS_PRESCALE 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STATUS 8'h0C

// Register field positions.
`define TRIM_MSB 6
`define PRESCALE_MSB 3
`define CTRL_POWER_DOWN 0
`define CTRL_CPU_IO_HALT 1

// Clock source codes (fuse value, 0 is programmed).
`define SRC_EXTERNAL 2'h0
`define SRC_RC_4M8 2'h1
`define SRC_RC_9M6 2'h2
`define SRC_LOW_POWER 2'h3

// Start-up codes.
`define STARTUP_SHORT 2'h0
`define STARTUP_4MS 2'h1
`define STARTUP_64MS 2'h2
`define STARTUP_RESERVED 2'h3

// Fuse polarity: a fuse bit at 0 is programmed.
`define FUSE_PROGRAMMED 1'b0

// Prescale reset values and the highest legal code.
`define PRESCALE_RESET_DIV1 4'h0
`define PRESCALE_RESET_DIV8 4'h3
`define PRESCALE_MAX_CODE 4'h8

// Start-up counts in source and watchdog oscillator cycles.
`define WAKE_SOURCE_CYCLES 6
`define RESET_SOURCE_CYCLES 14
`define WDT_CYCLES_4MS 512
`define WDT_CYCLES_64MS 8192

`endif

// *** osc_tick_sync.v ***
// Two-flop synchroniser with rising-edge pulse for one oscillator pin.
`timescale 1ns/1ps
`default_nettype none
module osc_tick_sync (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Asynchronous oscillator or request level.
    input wire async_in,
    // Synchronised level and one-cycle rising-edge pulse.
    output wire level_out,
    output wire rise_pulse
);
    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    // The first flop feeds only the second; edges are taken after it.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level_out = sync_reg;
    assign rise_pulse = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// *** clock_source_startup_control.v ***
// Clock source selection, start-up delays, trim load and system prescaler.
//
// How it works
// - Source code 00 external, 01/10 internal RC, 11 low-power oscillator.
// - A fuse bit at 0 counts as programmed, at 1 as unprogrammed.
// - Wake from power-down counts selected source cycles before execution resumes.
// - Reset start adds a delay counted on the watchdog oscillator.
// - Watchdog count is 512 cycles for 4 ms, 8192 for 64 ms.
// - Wake delay 6 cycles; reset 14, 14+4 ms, 14+64 ms; code 11 reserved.
// - Reset pin disabled with internal oscillator lengthens short reset delay to 4 ms.
// - RC code 10 gives full rate, code 01 half rate via divider.
// - Reset loads one factory trim byte; software may overwrite it later.
// - Watchdog and reset time-out always run from the watchdog oscillator.
// - Shipped fuses give 9.6 MHz RC, longest delay and prescale of 8.
// - Prescaler output drives CPU, I/O, ADC and flash clock enables.
// - ADC clock keeps running while CPU and I/O clocks are halted.
// - Prescale resets to 0000, or 0011 when divide-by-eight fuse is programmed.
// - Prescaler divides by two to the code, codes above 1000 reserved.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "clock_startup_defines.vh"
module clock_source_startup_control #(
    parameter WDT_CYCLES_4MS = `WDT_CYCLES_4MS,
    parameter WDT_CYCLES_64MS = `WDT_CYCLES_64MS
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Oscillator pins, asynchronous to pclk.
    input wire external_clock_input,
    input wire rc_osc_clock,
    input wire low_power_osc_clock,
    input wire watchdog_osc_clock,
    // Asynchronous wake-up request from power-down.
    input wire wake_request,
    // Static fuse settings, 0 means programmed.
    input wire [1:0] clock_source_select,
    input wire [1:0] startup_time_select,
    input wire divide_by_eight_at_boot,
    input wire reset_pin_disable,
    // Factory calibration bytes.
    input wire [6:0] factory_trim_9m6,
    input wire [6:0] factory_trim_4m8,
    // Oscillator trim and watchdog tick.
    output wire [6:0] oscillator_trim_value,
    output wire watchdog_timer_tick,
    // Core status and domain clock enables.
    output wire core_run,
    output reg cpu_clk_en,
    output reg io_clk_en,
    output reg flash_clk_en,
    output reg adc_clk_en
);
    localparam ST_LOAD = 3'h0;
    localparam ST_RST_WDT = 3'h1;
    localparam ST_RST_CK = 3'h2;
    localparam ST_RUN = 3'h3;
    localparam ST_SLEEP = 3'h4;
    localparam ST_WAKE = 3'h5;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [13:0] count_reg;
    reg [13:0] count_next;
    reg [1:0] src_sel_reg;
    reg [1:0] startup_sel_reg;
    reg div8_fuse_reg;
    reg rst_dis_fuse_reg;
    reg [6:0] trim_reg;
    reg [3:0] prescale_reg;
    reg power_down_reg;
    reg halt_reg;
    reg rc_half_reg;
    reg [7:0] div_count_reg;
    reg [13:0] wdt_target;
    reg src_tick;

    wire ext_tick;
    wire rc_tick;
    wire lp_tick;
    wire wdt_tick;
    wire wake_level;
    wire wr_en;
    wire rd_setup;
    wire addr_ok;
    wire sys_tick;

    // Division limit for a prescale code: two to the code, minus one.
    function [7:0] div_limit;
        input [3:0] code;
        begin
            div_limit = (8'h01 << code[2:0]) - 8'h01;
            if (code[3]) begin
                div_limit = 8'hFF;
            end
        end
    endfunction

    // Oscillator and wake pins are synchronised before use.
    osc_tick_sync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(external_clock_input),
        .level_out(),
        .rise_pulse(ext_tick)
    );
    osc_tick_sync u_rc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(rc_osc_clock),
        .level_out(),
        .rise_pulse(rc_tick)
    );
    osc_tick_sync u_lp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(low_power_osc_clock),
        .level_out(),
        .rise_pulse(lp_tick)
    );
    osc_tick_sync u_wdt_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(watchdog_osc_clock),
        .level_out(),
        .rise_pulse(wdt_tick)
    );
    osc_tick_sync u_wake_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(wake_request),
        .level_out(wake_level),
        .rise_pulse()
    );

    // The watchdog tick is independent of the selected system source.
    assign watchdog_timer_tick = wdt_tick;

    // Half-rate RC ticks come from a divider on the same oscillator.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_half_reg <= 1'b0;
        end else if (rc_tick) begin
            rc_half_reg <= ~rc_half_reg;
        end
    end

    // Select the tick of the chosen source.
    always @* begin
        case (src_sel_reg)
            `SRC_EXTERNAL: src_tick = ext_tick;
            `SRC_RC_4M8: src_tick = rc_tick & rc_half_reg;
            `SRC_RC_9M6: src_tick = rc_tick;
            default: src_tick = lp_tick;
        endcase
    end

    // Watchdog cycles of reset delay for the captured start-up code.
    always @* begin
        case (startup_sel_reg)
            `STARTUP_SHORT: begin
                wdt_target = 14'h0000;
                if (rst_dis_fuse_reg == `FUSE_PROGRAMMED && src_sel_reg != `SRC_EXTERNAL) begin
                    wdt_target = WDT_CYCLES_4MS[13:0];
                end
            end
            `STARTUP_4MS: wdt_target = WDT_CYCLES_4MS[13:0];
            default: wdt_target = WDT_CYCLES_64MS[13:0];
        endcase
    end

    // Start-up sequencer: reset delay, run, sleep and wake delay.
    always @* begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            ST_LOAD: begin
                state_next = ST_RST_WDT;
                count_next = 14'h0000;
            end
            ST_RST_WDT: begin
                if (count_reg >= wdt_target) begin
                    state_next = ST_RST_CK;
                    count_next = 14'h0000;
                end else if (wdt_tick) begin
                    count_next = count_reg + 14'h0001;
                end
            end
            ST_RST_CK: begin
                if (count_reg >= `RESET_SOURCE_CYCLES) begin
                    state_next = ST_RUN;
                end else if (src_tick) begin
                    count_next = count_reg + 14'h0001;
                end
            end
            ST_RUN: begin
                if (power_down_reg) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_level) begin
                    state_next = ST_WAKE;
                    count_next = 14'h0000;
                end
            end
            ST_WAKE: begin
                if (count_reg >= `WAKE_SOURCE_CYCLES) begin
                    state_next = ST_RUN;
                end else if (src_tick) begin
                    count_next = count_reg + 14'h0001;
                end
            end
            default: begin
                state_next = ST_LOAD;
                count_next = 14'h0000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_LOAD;
            count_reg <= 14'h0000;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // Fuses are held static; they are captured once, just after reset release.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_sel_reg <= `SRC_RC_9M6;
            startup_sel_reg <= `STARTUP_64MS;
            div8_fuse_reg <= `FUSE_PROGRAMMED;
            rst_dis_fuse_reg <= 1'b1;
        end else if (state_reg == ST_LOAD) begin
            src_sel_reg <= clock_source_select;
            startup_sel_reg <= startup_time_select;
            div8_fuse_reg <= divide_by_eight_at_boot;
            rst_dis_fuse_reg <= reset_pin_disable;
        end
    end

    // APB decode; the slave never waits.
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == `OFS_TRIM) | (paddr == `OFS_PRESCALE) |
                     (paddr == `OFS_CONTROL) | (paddr == `OFS_STATUS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    // Trim register: loaded from one factory byte at reset, then writable.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_reg <= 7'h00;
        end else if (state_reg == ST_LOAD) begin
            trim_reg <= factory_trim_9m6;
        end else if (wr_en && paddr == `OFS_TRIM) begin
            trim_reg <= pwdata[`TRIM_MSB:0];
        end
    end
    assign oscillator_trim_value = trim_reg;

    // Prescale select: fuse-dependent reset value, reserved codes are ignored.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale_reg <= `PRESCALE_RESET_DIV8;
        end else if (state_reg == ST_LOAD) begin
            if (divide_by_eight_at_boot == `FUSE_PROGRAMMED) begin
                prescale_reg <= `PRESCALE_RESET_DIV8;
            end else begin
                prescale_reg <= `PRESCALE_RESET_DIV1;
            end
        end else if (wr_en && paddr == `OFS_PRESCALE &&
                     pwdata[`PRESCALE_MSB:0] <= `PRESCALE_MAX_CODE) begin
            prescale_reg <= pwdata[`PRESCALE_MSB:0];
        end
    end

    // Control bits: power-down request self-clears once sleep is entered.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_down_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else if (wr_en && paddr == `OFS_CONTROL) begin
            power_down_reg <= pwdata[`CTRL_POWER_DOWN];
            halt_reg <= pwdata[`CTRL_CPU_IO_HALT];
        end else if (state_reg == ST_SLEEP) begin
            power_down_reg <= 1'b0;
        end
    end

    // Read data is registered in the setup phase and shown in the access phase.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            case (paddr)
                `OFS_TRIM: prdata <= {25'h0000000, trim_reg};
                `OFS_PRESCALE: prdata <= {28'h0000000, prescale_reg};
                `OFS_CONTROL: prdata <= {30'h00000000, halt_reg, power_down_reg};
                `OFS_STATUS: prdata <= {23'h000000, rst_dis_fuse_reg, div8_fuse_reg,
                                        startup_sel_reg, src_sel_reg, state_reg};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // System prescaler counts source ticks and emits one pulse per division.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count_reg <= 8'h00;
        end else if (src_tick) begin
            if (div_count_reg >= div_limit(prescale_reg)) begin
                div_count_reg <= 8'h00;
            end else begin
                div_count_reg <= div_count_reg + 8'h01;
            end
        end
    end
    assign sys_tick = src_tick & (div_count_reg >= div_limit(prescale_reg));
    assign core_run = (state_reg == ST_RUN);

    // Domain enables; the ADC domain ignores the CPU and I/O halt.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en <= 1'b0;
            io_clk_en <= 1'b0;
            flash_clk_en <= 1'b0;
            adc_clk_en <= 1'b0;
        end else begin
            cpu_clk_en <= sys_tick & core_run & ~halt_reg;
            io_clk_en <= sys_tick & core_run & ~halt_reg;
            flash_clk_en <= sys_tick & core_run & ~halt_reg;
            adc_clk_en <= sys_tick & core_run;
        end
    end
endmodule
`default_nettype wire

// *** osc_model.sv ***
// Free-running oscillator pins that feed the clock control block.
`timescale 1ns/1ps
`default_nettype none
module osc_model (
    // Oscillator pins.
    output logic ext_pin,
    output logic rc_pin,
    output logic lp_pin,
    output logic wdt_pin
);
    // All pins start low.
    initial begin
        {ext_pin, rc_pin, lp_pin, wdt_pin} = 4'h0;
    end
    // Fixed half periods toggle on falling pclk edges, so measured spacings are exact.
    always #250 ext_pin = ~ext_pin;
    always #200 rc_pin = ~rc_pin;
    always #350 lp_pin = ~lp_pin;
    always #300 wdt_pin = ~wdt_pin;
endmodule
`default_nettype wire

// *** clock_source_startup_control_chk.sv ***
// Concurrent checks on the ports of the clock source and start-up control block.
`timescale 1ns/1ps
`default_nettype none
`include "clock_startup_defines.vh"
module clock_source_startup_control_chk (
    // Clock, reset and APB requests.
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    // Oscillator, trim and status.
    input wire watchdog_osc_clock,
    input wire [6:0] factory_trim_9m6,
    input wire [6:0] oscillator_trim_value,
    input wire watchdog_timer_tick,
    input wire core_run,
    // Domain clock enables.
    input wire cpu_clk_en,
    input wire io_clk_en,
    input wire flash_clk_en,
    input wire adc_clk_en
);
    reg [7:0] cnt_reg;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since reset release, saturating.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) cnt_reg <= 8'h00;
        else if (cnt_reg != 8'hFF) cnt_reg <= cnt_reg + 8'h01;
    end
    AST_IO_FLASH: assert property (cpu_clk_en |-> io_clk_en && flash_clk_en)
        else $error("cpu enable alone");
    AST_ADC_FREE: assert property (cpu_clk_en |-> adc_clk_en)
        else $error("cpu enable without adc");
    AST_IDLE: assert property (!core_run && !$past(core_run) |-> !adc_clk_en)
        else $error("adc enable outside run");
    AST_WDT_TICK: assert property ($rose(watchdog_osc_clock) |-> ##[1:4] watchdog_timer_tick)
        else $error("watchdog edge lost");
    AST_WDT_PULSE: assert property (watchdog_timer_tick |=> !watchdog_timer_tick)
        else $error("watchdog tick too long");
    AST_TRIM_LOAD: assert property (cnt_reg == 8'h01 |-> oscillator_trim_value == factory_trim_9m6)
        else $error("trim not loaded");
    AST_TRIM_WRITE: assert property (psel && penable && pwrite && paddr == `OFS_TRIM
        |=> oscillator_trim_value == $past(pwdata[6:0]))
        else $error("trim write lost");
    AST_RUN_LATE: assert property ($rose(core_run) |-> cnt_reg > 8'h60)
        else $error("run too early");
endmodule
bind clock_source_startup_control clock_source_startup_control_chk chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .watchdog_osc_clock, .factory_trim_9m6, .oscillator_trim_value,
    .watchdog_timer_tick, .core_run, .cpu_clk_en, .io_clk_en, .flash_clk_en, .adc_clk_en);
`default_nettype wire

// *** tb_clock_source_startup_control.sv ***
// Self-checking bench for the clock source and start-up control block.
`timescale 1ns/1ps
`default_nettype none
`include "clock_startup_defines.vh"
`define CHK(a,e) begin checks_done++; if ((a)!==(e)) begin err_total++; $display("Error %0t %h %h",$time,a,e); end end
module tb_clock_source_startup_control;
    // Bench drive, observation and bookkeeping.
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic wake_request = 1'b0, rpd = 1'b1, d8 = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [1:0] src = 2'h2, start_code = 2'h2;
    logic [6:0] f96 = 7'h00, f48 = 7'h00;
    logic [15:0] lf = 16'hD95A;
    logic [32:0] q[$];
    wire [31:0] prdata;
    wire [6:0] trim;
    wire pready, pslverr, ext, rc, lp, wdt, tick, run, cpu, io, fl, adc;
    int err_total = 0, checks_done = 0, n, i, p;
    // Fuse table: source, start-up, reset pin, divide fuse, expected watchdog count.
    int s_t[6] = '{2, 0, 1, 3, 0, 2};
    int u_t[6] = '{2, 0, 1, 3, 0, 0};
    int r_t[6] = '{1, 1, 1, 1, 0, 0};
    int d_t[6] = '{0, 1, 1, 1, 1, 1};
    int w_t[6] = '{8, 0, 4, 8, 0, 4};
    int per[4] = '{10, 16, 8, 14};
    always #25 pclk = ~pclk;
    clock_source_startup_control #(.WDT_CYCLES_4MS(4), .WDT_CYCLES_64MS(8)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .external_clock_input(ext), .rc_osc_clock(rc), .low_power_osc_clock(lp), .watchdog_osc_clock(wdt),
        .wake_request, .clock_source_select(src), .startup_time_select(start_code), .divide_by_eight_at_boot(d8),
        .reset_pin_disable(rpd), .factory_trim_9m6(f96), .factory_trim_4m8(f48), .oscillator_trim_value(trim),
        .watchdog_timer_tick(tick), .core_run(run), .cpu_clk_en(cpu), .io_clk_en(io), .flash_clk_en(fl),
        .adc_clk_en(adc));
    osc_model osc (.ext_pin(ext), .rc_pin(rc), .lp_pin(lp), .wdt_pin(wdt));
    function automatic logic [15:0] nx(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // Expected status word for a given sequencer state.
    function automatic logic [32:0] st(input logic [2:0] s);
        return {24'h000000, rpd, d8, start_code, src, s};
    endfunction
    task automatic report_and_stop;
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int j;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (j = 0; j < 20; j++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (j == 20) begin
            err_total++;
            report_and_stop;
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Queue the expected error flag and data, then read.
    task automatic rdc(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h00000000);
    endtask
    // Each completed read is compared with the oldest queued note.
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            `CHK({pslverr, prdata}, q.pop_front())
        end
    end
    // Wait for core_run or an adc enable pulse, counting cycles.
    task automatic wt(input logic s, output int k);
        for (k = 1; k < 6000; k++) begin
            @(posedge pclk);
            #1;
            if ((s ? adc : run) === 1'b1) return;
        end
        err_total++;
        report_and_stop;
    endtask
    // Reset under one fuse setting, time the start-up, check trim, prescale and rate.
    task automatic boot(input int e);
        @(posedge pclk);
        presetn <= 1'b0;
        src <= 2'(s_t[e]);
        start_code <= 2'(u_t[e]);
        rpd <= 1'(r_t[e]);
        d8 <= 1'(d_t[e]);
        lf = nx(lf);
        f96 <= lf[6:0];
        f48 <= ~lf[6:0];
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wt(1'b0, n);
        p = per[s_t[e]];
        `CHK(n >= w_t[e] * 12 + 13 * p - 12 && n <= w_t[e] * 12 + 14 * p + 8, 1'b1)
        rdc(`OFS_TRIM, {26'h0, f96});
        rdc(`OFS_PRESCALE, d8 ? 33'h0 : 33'h3);
        rdc(`OFS_STATUS, st(3'h3));
        repeat (3) wt(1'b1, n);
        `CHK(n, d8 ? p : 8 * p)
    endtask
    // Main sequence.
    initial begin
        for (i = 0; i < 6; i++) boot(i);
        for (i = 0; i <= 8; i++) begin
            wr(`OFS_PRESCALE, 32'(i));
            repeat (3) wt(1'b1, n);
            `CHK(n, 8 << i)
        end
        wr(`OFS_PRESCALE, 32'h9);
        rdc(`OFS_PRESCALE, 33'h8);
        wr(`OFS_PRESCALE, 32'h0);
        wr(`OFS_CONTROL, 32'h1);
        rdc(`OFS_STATUS, st(3'h4));
        `CHK(run, 1'b0)
        wake_request <= 1'b1;
        wt(1'b0, n);
        `CHK(n >= 40 && n <= 60, 1'b1)
        wake_request <= 1'b0;
        wr(`OFS_CONTROL, 32'h2);
        repeat (2) wt(1'b1, n);
        `CHK({cpu, io, fl, adc}, 4'h1)
        wr(`OFS_CONTROL, 32'h0);
        repeat (2) wt(1'b1, n);
        `CHK({cpu, io, fl, adc}, 4'hF)
        lf = nx(lf);
        wr(`OFS_TRIM, {16'h0, lf});
        rdc(`OFS_TRIM, {26'h0, lf[6:0]});
        wr(`OFS_STATUS, 32'hFFFFFFFF);
        rdc(`OFS_STATUS, st(3'h3));
        rdc(8'h10, {1'b1, 32'h0});
        repeat (2) @(posedge pclk);
        report_and_stop;
    end
endmodule
`default_nettype wire
